// *** tah_pkg.sv ***
// Purpose: Shared constants and types for the translated bus control ends
// Assumes: One 200 MHz clock; pins modelled as separate in/out/enable signals
// Notes:   Both ends and the interface use these names
package tah_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned ADDR_W         = 24;
  localparam int unsigned UPPER_W        = 8;
  localparam int unsigned BE_W           = 4;
  localparam int unsigned STAT_W         = 4;
  localparam logic [3:0]  ST_RMW         = 4'hb;
  localparam logic [3:0]  ST_IFETCH      = 4'h8;
  localparam logic [3:0]  ST_DATA        = 4'ha;
  localparam logic [3:0]  BE_LOW_HALF    = 4'h3;
  localparam logic [3:0]  BE_HIGH_HALF   = 4'hc;
  localparam logic [3:0]  BE_NONE        = 4'hf;
  localparam logic [1:0]  RESET_LOW_MIN  = 2'h2;
  localparam logic [2:0]  HOLD_LATE_CNT  = 3'h2;

  typedef enum logic [2:0] {
    TAH_IDLE, TAH_T1, TAH_TMMU, TAH_TF, TAH_T2, TAH_T3, TAH_T4, TAH_HELD
  } tah_state_e;
endpackage : tah_pkg

// *** tah_bus_if.sv ***
// Purpose: Pin-level link between processor end and translator/master end
// Assumes: Two-way pins split into input, output and output enable
// Notes:   Shared wire levels are left unresolved; no module combines the two drivers
`timescale 1ns/1ps
interface tah_bus_if;
  logic                            translation_strap_pin;
  logic                            strobe_or_float_out;
  logic                            strobe_or_float_oe;
  logic                            float_command_n;
  logic                            reset_or_abort_pin_n;
  logic [tah_pkg::ADDR_W-1:0]      ad_out;
  logic                            ad_oe;
  logic [tah_pkg::ADDR_W-1:0]      ad_drive_ext;
  logic                            ad_ext_oe;
  logic [tah_pkg::UPPER_W-1:0]     upper_data_out;
  logic                            upper_data_oe;
  logic                            address_strobe_output_n;
  logic                            direction_output;
  logic                            ctrl_oe;
  logic [tah_pkg::BE_W-1:0]        byte_enables_n;
  logic [tah_pkg::STAT_W-1:0]      cycle_status_lines;
  logic                            physical_address_valid_n;
  logic                            physical_a1_input;
  logic                            hold_n;
  logic                            bus_grant_output_n;
  logic                            program_flow_pulse_n;
  logic                            user_mode;
  logic                            interlock_output_n;

  modport cpu (
    input  translation_strap_pin, float_command_n, reset_or_abort_pin_n,
    input  physical_a1_input, hold_n,
    output strobe_or_float_out, strobe_or_float_oe, ad_out, ad_oe, upper_data_out,
    output upper_data_oe, address_strobe_output_n, direction_output, ctrl_oe,
    output byte_enables_n, cycle_status_lines, bus_grant_output_n,
    output program_flow_pulse_n, user_mode, interlock_output_n
  );
  modport ext (
    output translation_strap_pin, float_command_n, reset_or_abort_pin_n,
    output physical_a1_input, hold_n, ad_drive_ext, ad_ext_oe,
    output physical_address_valid_n,
    input  address_strobe_output_n, ad_out, ad_oe, cycle_status_lines,
    input  bus_grant_output_n, direction_output
  );
endinterface : tah_bus_if

// *** tah_cpu_end.sv ***
// Purpose: Processor bus control with translation, float, abort and hold
// Assumes: Pins synchronous to clk; reset_or_abort_pin_n low one clock = abort
// Notes:   Execution unit is abstracted to request and status ports
`timescale 1ns/1ps
module tah_cpu_end (
  // Clock and reset
  input  wire logic                            clk,
  input  wire logic                            reset,
  // Pins
  tah_bus_if.cpu                               bus,
  // Execution unit side
  input  wire logic                            cyc_req,
  input  wire logic                            cyc_write,
  input  wire logic                            cyc_prefetch,
  input  wire logic                            cyc_rmw,
  input  wire logic [tah_pkg::ADDR_W-1:0]      cyc_addr,
  input  wire logic [31:0]                     cyc_wdata,
  input  wire logic [tah_pkg::BE_W-1:0]        cyc_be_n,
  input  wire logic                            instr_start,
  input  wire logic                            queue_empty_exec,
  input  wire logic                            psr_user,
  input  wire logic                            interlocked_bit_op,
  output logic                                 cyc_done,
  output logic                                 abort_trap,
  output logic                                 abort_retryable,
  output logic                                 prefetch_stopped,
  output logic                                 pin_reset,
  output logic                                 translated_mode
);
  tah_pkg::tah_state_e state;
  tah_pkg::tah_state_e next_state;
  logic                        rst_pin_d;
  logic [1:0]                  low_cnt;
  logic                        abort_pending;
  logic                        abort_in_window;
  logic                        abort_armed;
  logic                        cur_prefetch;
  logic                        cur_write;
  logic                        cur_rmw;
  logic [tah_pkg::ADDR_W-1:0]  cur_addr;
  logic [31:0]                 cur_wdata;
  logic [tah_pkg::BE_W-1:0]    cur_be_n;
  logic                        hold_seen;

  // Abort recognised when the pin returns high after exactly one low clock
  wire abort_pulse    = bus.reset_or_abort_pin_n && !rst_pin_d && low_cnt == 2'h1;
  wire float_low      = translated_mode && !bus.float_command_n;
  wire in_window      = state == tah_pkg::TAH_TMMU || state == tah_pkg::TAH_TF;
  // The pulse is only confirmed one clock after the low, by then the state has moved on
  wire abort_hit      = abort_pulse && abort_armed;
  wire abort_now      = (abort_hit || (abort_pending && in_window)) && !float_low;
  wire hold_req       = !bus.hold_n;
  wire late_hold      = state == tah_pkg::TAH_T3 || state == tah_pkg::TAH_T4;
  wire grant_ok       = hold_req && (state == tah_pkg::TAH_IDLE && !cyc_req);
  wire release_at_t4  = hold_seen && state == tah_pkg::TAH_T4;

  always_comb begin
    next_state = state;
    unique case (state)
      tah_pkg::TAH_IDLE: begin
        if (grant_ok)
          next_state = tah_pkg::TAH_HELD;
        else if (cyc_req)
          next_state = tah_pkg::TAH_T1;
      end
      tah_pkg::TAH_T1:
        next_state = translated_mode ? tah_pkg::TAH_TMMU : tah_pkg::TAH_T2;
      tah_pkg::TAH_TMMU, tah_pkg::TAH_TF: begin
        if (float_low)
          next_state = tah_pkg::TAH_TF;
        else
          next_state = tah_pkg::TAH_T2;
      end
      tah_pkg::TAH_T2:
        next_state = (abort_in_window || abort_now) ? tah_pkg::TAH_IDLE
                                                    : tah_pkg::TAH_T3;
      tah_pkg::TAH_T3:
        next_state = tah_pkg::TAH_T4;
      tah_pkg::TAH_T4:
        next_state = release_at_t4 ? tah_pkg::TAH_HELD : tah_pkg::TAH_IDLE;
      tah_pkg::TAH_HELD:
        next_state = hold_req ? tah_pkg::TAH_HELD : tah_pkg::TAH_IDLE;
    endcase
  end

  // Reset vs abort discrimination counts low clocks on the shared pin
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rst_pin_d <= 1'b1;
      // Reset counts as a long low, so the strap is caught when the pin rises
      low_cnt   <= tah_pkg::RESET_LOW_MIN;
      pin_reset <= 1'b1;
    end else begin
      rst_pin_d <= bus.reset_or_abort_pin_n;
      if (!bus.reset_or_abort_pin_n) begin
        if (low_cnt != tah_pkg::RESET_LOW_MIN)
          low_cnt <= low_cnt + 2'h1;
      end else begin
        low_cnt <= 2'h0;
      end
      pin_reset <= !bus.reset_or_abort_pin_n && low_cnt != 2'h0;
    end
  end

  // Strap caught when the pin rises at the end of pin reset, frozen afterwards
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      translated_mode <= 1'b0;
    else if (pin_reset && bus.reset_or_abort_pin_n)
      translated_mode <= !bus.translation_strap_pin;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= tah_pkg::TAH_IDLE;
    end else if (pin_reset) begin
      state <= tah_pkg::TAH_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cur_prefetch <= 1'b0;
      cur_write    <= 1'b0;
      cur_rmw      <= 1'b0;
      cur_addr     <= '0;
      cur_wdata    <= '0;
      cur_be_n     <= tah_pkg::BE_NONE;
    end else if (state == tah_pkg::TAH_IDLE && cyc_req && !grant_ok) begin
      cur_prefetch <= cyc_prefetch;
      cur_write    <= cyc_write;
      cur_rmw      <= cyc_rmw && !cyc_write;
      cur_addr     <= cyc_addr;
      cur_wdata    <= cyc_wdata;
      cur_be_n     <= cyc_be_n;
    end
  end

  // Abort seen while float is low is held until float is removed
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      abort_pending   <= 1'b0;
      abort_in_window <= 1'b0;
      abort_armed     <= 1'b0;
    end else begin
      abort_armed <= !bus.reset_or_abort_pin_n && in_window;
      if (abort_now || state == tah_pkg::TAH_IDLE)
        abort_pending <= 1'b0;
      else if (abort_hit && float_low)
        abort_pending <= 1'b1;
      if (abort_now && state != tah_pkg::TAH_T2)
        abort_in_window <= 1'b1;
      else if (state == tah_pkg::TAH_T2)
        abort_in_window <= 1'b0;
    end
  end

  // Hold sampled early in the cycle is honoured at T4; later requests wait
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      hold_seen <= 1'b0;
    else if (state == tah_pkg::TAH_IDLE || state == tah_pkg::TAH_HELD)
      hold_seen <= 1'b0;
    else if (hold_req && !late_hold)
      hold_seen <= 1'b1;
  end

  // Trap reporting toward the execution unit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      abort_trap       <= 1'b0;
      abort_retryable  <= 1'b0;
      prefetch_stopped <= 1'b0;
      cyc_done         <= 1'b0;
    end else begin
      cyc_done <= state == tah_pkg::TAH_T4;
      if (instr_start && !queue_empty_exec)
        prefetch_stopped <= 1'b0;
      else if (abort_now && cur_prefetch)
        prefetch_stopped <= 1'b1;
      // Trap is taken once when the queue runs dry, then prefetching resumes
      else if (queue_empty_exec)
        prefetch_stopped <= 1'b0;
      abort_trap      <= (abort_now && !cur_prefetch) ||
                         (prefetch_stopped && queue_empty_exec) ||
                         (abort_pulse && !abort_armed && !pin_reset);
      abort_retryable <= (abort_now && !cur_prefetch) ||
                         (prefetch_stopped && queue_empty_exec);
    end
  end

  // Status code of a cycle; the request's own code is shown from T1 on
  function automatic logic [tah_pkg::STAT_W-1:0] status_code(input logic read_modify_write_status, input logic pf);
    return read_modify_write_status ? tah_pkg::ST_RMW : pf ? tah_pkg::ST_IFETCH : tah_pkg::ST_DATA;
  endfunction : status_code

  // Pin drivers
  wire start_t1  = next_state == tah_pkg::TAH_T1;
  wire [tah_pkg::STAT_W-1:0] req_status = status_code(cyc_rmw && !cyc_write, cyc_prefetch);
  wire [tah_pkg::STAT_W-1:0] cur_status = status_code(cur_rmw, cur_prefetch);
  wire held      = state == tah_pkg::TAH_HELD;
  wire float_ad  = held || state == tah_pkg::TAH_TMMU || state == tah_pkg::TAH_TF;
  wire data_ph   = state == tah_pkg::TAH_T3 || state == tah_pkg::TAH_T4;
  wire upper_own = cur_write && data_ph && !float_ad;
  wire [tah_pkg::BE_W-1:0] a1_be = bus.physical_a1_input ? tah_pkg::BE_HIGH_HALF
                                                          : tah_pkg::BE_LOW_HALF;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bus.ad_out                  <= '0;
      bus.ad_oe                   <= 1'b0;
      bus.upper_data_out          <= '0;
      bus.upper_data_oe           <= 1'b0;
      bus.address_strobe_output_n <= 1'b1;
      bus.direction_output        <= 1'b1;
      bus.ctrl_oe                 <= 1'b1;
      bus.byte_enables_n          <= tah_pkg::BE_NONE;
      bus.cycle_status_lines      <= '0;
      bus.strobe_or_float_out     <= 1'b1;
      bus.strobe_or_float_oe      <= 1'b0;
      bus.bus_grant_output_n      <= 1'b1;
    end else begin
      bus.ad_oe  <= !(next_state == tah_pkg::TAH_TMMU || next_state == tah_pkg::TAH_TF ||
                      next_state == tah_pkg::TAH_HELD);
      bus.ad_out <= (next_state == tah_pkg::TAH_T1) ? cyc_addr : cur_wdata[tah_pkg::ADDR_W-1:0];
      bus.upper_data_out <= cur_wdata[31:tah_pkg::ADDR_W];
      bus.upper_data_oe  <= upper_own;
      bus.address_strobe_output_n <= !(next_state == tah_pkg::TAH_T1);
      bus.direction_output <= start_t1 ? !cyc_write : !cur_write;
      bus.ctrl_oe <= !(next_state == tah_pkg::TAH_HELD || next_state == tah_pkg::TAH_TF);
      bus.byte_enables_n <= (state == tah_pkg::TAH_TF) ? a1_be : cur_be_n;
      bus.cycle_status_lines <= start_t1 ? req_status : cur_status;
      // Strobe pin drives only in untranslated mode
      bus.strobe_or_float_oe  <= !translated_mode;
      bus.strobe_or_float_out <= !(data_ph && !translated_mode);
      // Acknowledge raised one clock after address and control lines are floated
      bus.bus_grant_output_n  <= !(held && next_state == tah_pkg::TAH_HELD);
    end
  end

  // Instruction status is tied to execution, not to bus states
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bus.program_flow_pulse_n <= 1'b1;
      bus.user_mode            <= 1'b0;
      bus.interlock_output_n   <= 1'b1;
    end else begin
      bus.program_flow_pulse_n <= !instr_start;
      bus.user_mode            <= psr_user;
      bus.interlock_output_n   <= !interlocked_bit_op;
    end
  end
endmodule : tah_cpu_end

// *** tah_ext_end.sv ***
// Purpose: Translator and bus master end facing the processor pins
// Assumes: Translation itself done by user logic; this end sequences pins
// Notes:   Aborts are one-clock pulses; reset is a multi-clock low
`timescale 1ns/1ps
module tah_ext_end (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset,
  // Pins
  tah_bus_if.ext                           bus,
  // User side
  input  wire logic                        strap_translate,
  input  wire logic                        pin_reset_req,
  input  wire logic                        need_float,
  input  wire logic                        deny_access,
  input  wire logic [tah_pkg::ADDR_W-1:0]  phys_addr,
  input  wire logic                        phys_a1,
  input  wire logic                        dma_req,
  output logic                             dma_granted,
  output logic                             in_translation
);
  logic stretch;
  logic last_rmw;
  wire  in_tmmu  = !bus.address_strobe_output_n;
  // Never abort the write half of a read-modify-write
  wire  may_abort = bus.direction_output || !last_rmw;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bus.translation_strap_pin    <= 1'b1;
      bus.reset_or_abort_pin_n     <= 1'b0;
      bus.float_command_n          <= 1'b1;
      bus.physical_a1_input        <= 1'b0;
      bus.hold_n                   <= 1'b1;
      bus.ad_drive_ext             <= '0;
      bus.ad_ext_oe                <= 1'b0;
      bus.physical_address_valid_n <= 1'b1;
      stretch                      <= 1'b0;
      last_rmw                     <= 1'b0;
      dma_granted                  <= 1'b0;
      in_translation               <= 1'b0;
    end else begin
      bus.translation_strap_pin <= !strap_translate;
      in_translation <= in_tmmu;
      bus.physical_a1_input <= phys_a1;
      // Float started in the translation state and held by stretch while need_float stays high
      if (in_tmmu && need_float)
        stretch <= 1'b1;
      else if (!need_float)
        stretch <= 1'b0;
      bus.float_command_n <= !((in_tmmu || stretch) && need_float);
      if (in_tmmu)
        last_rmw <= bus.cycle_status_lines == tah_pkg::ST_RMW;
      // Abort pulse lies in the translation state, ahead of any float release
      bus.reset_or_abort_pin_n <= !(pin_reset_req ||
                                    (in_tmmu && deny_access && may_abort));
      bus.ad_ext_oe <= in_tmmu && !need_float;
      bus.ad_drive_ext <= phys_addr;
      bus.physical_address_valid_n <= !(in_tmmu && !need_float && !deny_access);
      bus.hold_n <= !dma_req;
      dma_granted <= !bus.bus_grant_output_n && dma_req;
    end
  end
endmodule : tah_ext_end

// *** tah_assertions.sv ***
// Purpose: Pin-level checks between the processor end and the translator end
// Assumes: Mode copy relatched only after a reset-length low on the pin
// Notes:   Watches interface signals only
`timescale 1ns/1ps
module tah_assertions (
  // Clock and reset
  input wire logic                       clk,
  input wire logic                       reset,
  // Pins
  input wire logic                       translation_strap_pin,
  input wire logic                       strobe_or_float_oe,
  input wire logic                       float_command_n,
  input wire logic                       reset_or_abort_pin_n,
  input wire logic                       ad_oe,
  input wire logic                       upper_data_oe,
  input wire logic                       ctrl_oe,
  input wire logic                       address_strobe_output_n,
  input wire logic [tah_pkg::BE_W-1:0]   byte_enables_n,
  input wire logic                       physical_a1_input,
  input wire logic                       hold_n,
  input wire logic                       bus_grant_output_n
);
  logic [1:0] low_cnt;
  logic       tmode;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // A one-clock abort low must not relatch the mode copy
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      low_cnt <= tah_pkg::RESET_LOW_MIN;
      tmode   <= 1'b0;
    end else if (!reset_or_abort_pin_n) begin
      low_cnt <= (low_cnt == 2'h3) ? low_cnt : low_cnt + 2'h1;
    end else begin
      low_cnt <= 2'h0;
      tmode   <= (low_cnt >= tah_pkg::RESET_LOW_MIN) ? !translation_strap_pin : tmode;
    end
  end

  AST_HOLD_FLOAT: assert property (!bus_grant_output_n |-> !ad_oe && !upper_data_oe && !ctrl_oe)
    else $error("bus driven while granted");
  AST_GRANT_STANDS: assert property (!bus_grant_output_n && !hold_n |=> !bus_grant_output_n)
    else $error("grant dropped while hold requested");
  AST_GRANT_RETURN: assert property (!bus_grant_output_n && hold_n |-> ##[1:3] bus_grant_output_n)
    else $error("grant kept after hold released");
  AST_HOLD_BOUND: assert property ($fell(hold_n) |-> ##[1:40] !bus_grant_output_n)
    else $error("hold not granted in time");
  AST_ADS_ONE: assert property ($fell(address_strobe_output_n) |=> address_strobe_output_n)
    else $error("address strobe longer than one clock");
  AST_TMMU_FLOAT: assert property (tmode && $fell(address_strobe_output_n) |=> !ad_oe)
    else $error("address lines driven in translation state");
  AST_FLT_INPUT: assert property (tmode && $stable(tmode) |-> !strobe_or_float_oe)
    else $error("strobe pin driven in translated mode");
  AST_FLOAT_STATE: assert property (tmode && bus_grant_output_n && !float_command_n
      && !$past(float_command_n) && !$past(float_command_n, 2) |-> !ad_oe && !upper_data_oe
      && byte_enables_n == ($past(physical_a1_input) ? tah_pkg::BE_HIGH_HALF
      : tah_pkg::BE_LOW_HALF))
    else $error("float state pins wrong");
endmodule : tah_assertions

// *** tb_cpu_translation_abort_hold_interface.sv ***
// Purpose: Joins both ends and checks them against fixed expected values
// Assumes: Outputs settle 1 ns after the edge
// Notes:   Float is dropped a few clocks into a stretched cycle
`timescale 1ns/1ps
module tb_cpu_translation_abort_hold_interface;
  logic clk, reset, cyc_req, cyc_write, cyc_prefetch, cyc_rmw, instr_start;
  logic queue_empty_exec, psr_user, interlocked_bit_op, cyc_done, abort_trap;
  logic abort_retryable, prefetch_stopped, pin_reset, translated_mode;
  logic strap_translate, pin_reset_req, need_float, deny_access, phys_a1, dma_req;
  logic dma_granted, in_translation, seen_tr;
  logic [tah_pkg::ADDR_W-1:0] cyc_addr, phys_addr;
  logic [31:0]                cyc_wdata, seed;
  logic [3:0]                 cyc_be_n, st;
  logic [1:0]                 ab;
  logic [3:0]                 exp_st[$] = '{tah_pkg::ST_DATA, tah_pkg::ST_IFETCH, tah_pkg::ST_RMW};
  int                         failures, checks, lat, n, cyc_cnt, done_cnt, d0;

  tah_bus_if bus ();
  tah_cpu_end i_tah_cpu_end (.clk(clk), .reset(reset), .bus(bus), .cyc_req(cyc_req),
    .cyc_write(cyc_write), .cyc_prefetch(cyc_prefetch), .cyc_rmw(cyc_rmw),
    .cyc_addr(cyc_addr), .cyc_wdata(cyc_wdata), .cyc_be_n(cyc_be_n),
    .instr_start(instr_start), .queue_empty_exec(queue_empty_exec), .psr_user(psr_user),
    .interlocked_bit_op(interlocked_bit_op), .cyc_done(cyc_done), .abort_trap(abort_trap),
    .abort_retryable(abort_retryable), .prefetch_stopped(prefetch_stopped),
    .pin_reset(pin_reset), .translated_mode(translated_mode));
  tah_ext_end i_tah_ext_end (.clk(clk), .reset(reset), .bus(bus),
    .strap_translate(strap_translate), .pin_reset_req(pin_reset_req),
    .need_float(need_float), .deny_access(deny_access), .phys_addr(phys_addr),
    .phys_a1(phys_a1), .dma_req(dma_req), .dma_granted(dma_granted),
    .in_translation(in_translation));
  tah_assertions i_tah_assertions (.clk(clk), .reset(reset),
    .translation_strap_pin(bus.translation_strap_pin),
    .strobe_or_float_oe(bus.strobe_or_float_oe), .float_command_n(bus.float_command_n),
    .reset_or_abort_pin_n(bus.reset_or_abort_pin_n), .ad_oe(bus.ad_oe),
    .upper_data_oe(bus.upper_data_oe), .ctrl_oe(bus.ctrl_oe),
    .address_strobe_output_n(bus.address_strobe_output_n),
    .byte_enables_n(bus.byte_enables_n), .physical_a1_input(bus.physical_a1_input),
    .hold_n(bus.hold_n), .bus_grant_output_n(bus.bus_grant_output_n));

  always #2.5 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  task automatic final_report;
    if (failures == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  task automatic chk_v(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_v

  // Runs one cycle; lat counts edges from the taking edge to the done pulse
  task automatic run_cycle(input logic pf, input logic read_modify_write_status, input logic float_command, input logic dny);
    seed = xs(seed);
    @(posedge clk);
    {cyc_prefetch, cyc_rmw, need_float, deny_access} <= {pf, read_modify_write_status, float_command, dny};
    {cyc_addr, cyc_wdata, cyc_write, cyc_be_n} <= {seed[23:0], seed, seed[4] & !pf & !read_modify_write_status, 4'h0};
    phys_addr <= seed[31:8];
    cyc_req <= 1'b1;
    ab = 2'b00;
    seen_tr = 1'b0;
    @(posedge clk);
    cyc_req <= 1'b0;
    for (lat = 1; lat < 20; lat++) begin
      #1;
      if (!bus.address_strobe_output_n) st = bus.cycle_status_lines;
      ab = ab | {abort_trap, abort_retryable};
      seen_tr = seen_tr | (in_translation === 1'b1);
      if (cyc_done === 1'b1) break;
      @(posedge clk);
      if (lat == 4) need_float <= 1'b0;
    end
    @(posedge clk);
    {need_float, deny_access} <= 2'b00;
  endtask : run_cycle

  always @(posedge clk) begin
    done_cnt <= done_cnt + (cyc_done === 1'b1);
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      failures++;
      final_report();
    end
  end

  initial begin
    {clk, reset, strap_translate, seed, cyc_cnt, done_cnt} = {3'b011, 32'h2563, 64'h0};
    {cyc_req, cyc_write, cyc_prefetch, cyc_rmw, instr_start, queue_empty_exec} = 6'h0;
    {psr_user, interlocked_bit_op, pin_reset_req, need_float, deny_access} = 5'h0;
    {cyc_addr, phys_addr, cyc_wdata, cyc_be_n, phys_a1, dma_req} = {80'h0, 4'hf, 2'b10};
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (5) @(posedge clk);
    chk_v("translated_mode", 1, translated_mode);
    for (int k = 0; k < 3; k++) begin
      run_cycle(k == 1, k == 2, 1'b0, 1'b0);
      chk_v("latency", 6, lat);
      chk_v("status", exp_st[k], st);
      chk_v("in_translation", 1, seen_tr);
    end
    run_cycle(1'b0, 1'b0, 1'b1, 1'b0);
    chk_v("stretched", 1, lat > 6);
    run_cycle(1'b0, 1'b0, 1'b0, 1'b1);
    chk_v("abort", 2'b11, ab);
    run_cycle(1'b0, 1'b0, 1'b1, 1'b1);
    chk_v("float abort", 2'b11, ab);
    run_cycle(1'b1, 1'b0, 1'b0, 1'b1);
    chk_v("prefetch trap", 0, ab[1]);
    chk_v("prefetch_stopped", 1, prefetch_stopped);
    chk_v("mode kept", 1, translated_mode);
    queue_empty_exec <= 1'b1;
    ab = 2'b00;
    repeat (10) begin
      @(posedge clk);
      ab[1] = ab[1] | (abort_trap === 1'b1);
    end
    chk_v("empty queue trap", 1, ab[1]);
    queue_empty_exec <= 1'b0;
    dma_req <= 1'b1;
    for (n = 0; n < 9 && bus.hold_n !== 1'b0; n++) @(posedge clk);
    for (n = 0; n < 9 && bus.bus_grant_output_n !== 1'b0; n++) @(posedge clk);
    chk_v("idle grant", 1, n <= 2);
    #1 chk_v("dma_granted", 1, dma_granted);
    @(posedge clk);
    dma_req <= 1'b0;
    for (n = 0; n < 9 && bus.bus_grant_output_n !== 1'b1; n++) @(posedge clk);
    chk_v("grant return", 1, n < 9);
    d0 = done_cnt;
    fork
      run_cycle(1'b0, 1'b0, 1'b0, 1'b0);
      begin
        repeat (3) @(posedge clk);
        dma_req <= 1'b1;
        for (n = 0; n < 30 && bus.bus_grant_output_n !== 1'b0; n++) @(posedge clk);
        chk_v("grant after cycle", d0 + 1, done_cnt);
        dma_req <= 1'b0;
      end
    join
    repeat (6) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      {instr_start, psr_user, interlocked_bit_op} <= {1'b1, i[0], i[1]};
      @(posedge clk);
      instr_start <= 1'b0;
      #1 chk_v("flow pulse", 0, bus.program_flow_pulse_n);
      chk_v("user_mode", i[0], bus.user_mode);
      chk_v("interlock", !i[1], bus.interlock_output_n);
      @(posedge clk);
    end
    strap_translate <= 1'b0;
    repeat (4) @(posedge clk);
    chk_v("mode held", 1, translated_mode);
    pin_reset_req <= 1'b1;
    repeat (5) @(posedge clk);
    chk_v("pin_reset", 1, pin_reset);
    pin_reset_req <= 1'b0;
    repeat (6) @(posedge clk);
    chk_v("untranslated", 0, translated_mode);
    run_cycle(1'b0, 1'b0, 1'b0, 1'b0);
    chk_v("plain latency", 5, lat);
    final_report();
  end
endmodule : tb_cpu_translation_abort_hold_interface
